// ===== wms_sequencer.sv
// Purpose: mode, wake-up, reset and ground-offset logic of the sequencer
// Assumes: all inputs except asynchronous rst synchronous to mclk; comparators pre-synchronised
// Notes:   registers are plain ports; no bus in this block
// Behaviour
// - eight cyclic periods selected by timing field
// - switched output on 400 us each period
// - sample wake inputs 300 us after on
// - cyclic sensing only in sleep mode
// - cyclic sensing beats forced wake-up in sleep
// - permanent sensing normal/standby, gated by switched output
// - sleep: battery inputs permanent, switched inputs cyclic
// - live state, status flag, maskable interrupt
// - sleep wake sets flag, reset, then normal request
// - no detection in normal request or emergency
// - chip select fall wakes after regulator off
// - eight maskable interrupt sources drive interrupt
// - reset pin low for 1 ms
// - reset pin released by host enters normal request
// - two-bit ground offset level port unused; canh comparator result stored
// - canh below threshold at transmit fall sets flag
// - watchdog runs normal/standby; failure or undervoltage resets
// - sleep: regulators off, reset low, no interrupt
// - unconfigured 75 ms after forced wake returns sleep
// - cyclic wake needs two then two opposite samples
`timescale 1ns/1ps
module wms_sequencer
  import wms_pkg::*;
#(
  parameter int unsigned CFG_TMO = wms_pkg::CFG_TMO_CYC,
  parameter int unsigned RST_PULSE = wms_pkg::RST_PULSE_CYC,
  parameter int unsigned MS_CYC = wms_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // configuration
  input  wire logic [2:0]                   cyclic_timing_reg,
  input  wire logic                         cyclic_en,
  input  wire logic                         forced_wake_en,
  input  wire logic                         wake_from_switched,
  input  wire wms_pkg::wms_opt_e            wake_opt,
  input  wire logic [1:0]                   ground_offset_level,
  input  wire logic [wms_pkg::N_IRQ-1:0]    irq_mask,
  input  wire logic                         switched_on_req,
  input  wire wms_pkg::wms_cmd_s            cmd,
  // status clears, one-cycle pulses
  input  wire logic                         wake_status_clr,
  input  wire logic                         irq_two_clr,
  input  wire logic                         ground_offset_clr,
  // events and pins
  input  wire logic [wms_pkg::N_WAKE-1:0]   local_wake_inputs,
  input  wire logic [wms_pkg::N_IRQ-1:0]    irq_src,
  input  wire logic                         cs_n,
  input  wire logic                         can_tx,
  input  wire logic                         can_wake,
  input  wire logic                         wd_fail,
  input  wire wms_pkg::wms_cmp_s            cmp,
  input  wire logic                         rst_pin_in,
  // outputs
  output wms_pkg::wms_mode_e                mode,
  output logic                              main_regulator,
  output logic                              can_regulator,
  output logic                              switched_battery_out,
  output logic                              watchdog_run,
  output logic                              rst_pin_out,
  output logic                              rst_pin_oe,
  output logic                              irq_n,
  output logic [wms_pkg::N_WAKE-1:0]        wake_input_live_reg,
  output logic [wms_pkg::N_WAKE-1:0]        wake_input_status_reg,
  output logic                              irq_status_reg_two,
  output logic                              ground_offset_flag
);
  import wms_pkg::*;

  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W-1:0] per_len;
  logic [CNT_W-1:0] rst_cnt;
  logic [CNT_W-1:0] tmo_cnt;
  logic             period_tick;
  logic             cyc_active;
  logic             fwu_active;
  logic             sample_now;
  logic [N_WAKE-1:0] s0;
  logic [N_WAKE-1:0] s1;
  logic [N_WAKE-1:0] s2;
  logic [N_WAKE-1:0] s3;
  logic [1:0]        nsamp;
  logic [N_WAKE-1:0] prev_in;
  logic [N_WAKE-1:0] perm_hit;
  logic [N_WAKE-1:0] cyc_hit;
  logic [N_WAKE-1:0] hit;
  logic              perm_en;
  logic              cs_prev;
  logic              tx_prev;
  logic              rst_in_prev;
  logic              host_rst_rel;
  logic              cs_wake;
  logic              forced_wu;
  logic              from_forced;
  logic              pulse_busy;
  logic              go_reset;
  logic              in_sleep;
  logic              canh_low;

  assign in_sleep = (mode == WMS_SLEEP);
  assign cyc_active = in_sleep && cyclic_en;
  assign fwu_active = in_sleep && forced_wake_en && !cyclic_en;

  // period length: 32 ms doubling, top code jumps to 8192 ms
  always_comb begin
    if (cyclic_timing_reg == 3'h7) begin
      per_len = CNT_W'(PER_MS_7) * CNT_W'(MS_CYC);
    end else begin
      per_len = (CNT_W'(PER_MS_0) << cyclic_timing_reg) * CNT_W'(MS_CYC);
    end
  end

  assign period_tick = (per_cnt >= per_len - 1'b1);

  // period counter runs in sleep only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      per_cnt <= '0;
    end else if (!(cyc_active || fwu_active) || period_tick) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= per_cnt + 1'b1;
    end
  end

  // switched output: cyclic window or software request in normal and standby
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      switched_battery_out <= 1'b0;
    end else if (in_sleep) begin
      switched_battery_out <= cyc_active && (per_cnt < CNT_W'(SW_ON_CYC));
    end else begin
      switched_battery_out <= switched_on_req &&
        (mode == WMS_NORMAL || mode == WMS_STANDBY);
    end
  end

  assign sample_now = cyc_active && (per_cnt == CNT_W'(SAMPLE_CYC));

  // four-deep sample history for cyclic edge validation
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s0 <= '0;
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      nsamp <= 2'h0;
    end else if (!cyc_active) begin
      nsamp <= 2'h0;
    end else if (sample_now) begin
      s0 <= local_wake_inputs;
      s1 <= s0;
      s2 <= s1;
      s3 <= s2;
      if (nsamp != 2'h3) begin
        nsamp <= nsamp + 2'h1;
      end
    end
  end

  // oldest to newest: s3 s2 s1 s0
  always_comb begin
    for (int i = 0; i < N_WAKE; i++) begin
      cyc_hit[i] = 1'b0;
      if (nsamp == 2'h3 && sample_now) begin
        case (wake_opt)
          WMS_OPT_RISE: cyc_hit[i] = !s2[i] && !s1[i] && s0[i] &&
                                     local_wake_inputs[i];
          WMS_OPT_FALL: cyc_hit[i] = s2[i] && s1[i] && !s0[i] &&
                                     !local_wake_inputs[i];
          WMS_OPT_BOTH: cyc_hit[i] = (s2[i] == s1[i]) &&
                                     (s0[i] != s1[i]) &&
                                     (local_wake_inputs[i] == s0[i]);
          default:      cyc_hit[i] = 1'b0;
        endcase
      end
    end
  end

  // permanent sensing enable per mode and supply choice
  always_comb begin
    case (mode)
      WMS_NORMAL, WMS_STANDBY:
        perm_en = !wake_from_switched || switched_battery_out;
      WMS_SLEEP:
        perm_en = !wake_from_switched;
      default:
        perm_en = 1'b0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < N_WAKE; i++) begin
      case (wake_opt)
        WMS_OPT_RISE: perm_hit[i] = !prev_in[i] && local_wake_inputs[i];
        WMS_OPT_FALL: perm_hit[i] = prev_in[i] && !local_wake_inputs[i];
        WMS_OPT_BOTH: perm_hit[i] = prev_in[i] != local_wake_inputs[i];
        default:      perm_hit[i] = 1'b0;
      endcase
    end
  end

  assign hit = (perm_en ? perm_hit : '0) |
               ((in_sleep && wake_from_switched) ? cyc_hit : '0);

  // live state and edge reference
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_in <= '0;
      wake_input_live_reg <= '0;
    end else begin
      prev_in <= local_wake_inputs;
      if (mode == WMS_NORMAL || mode == WMS_STANDBY) begin
        wake_input_live_reg <= local_wake_inputs;
      end
    end
  end

  // sticky wake status, set wins over clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake_input_status_reg <= '0;
    end else begin
      wake_input_status_reg <= (wake_status_clr ? '0 : wake_input_status_reg)
                               | hit;
    end
  end

  // chip select wake once main regulator is fully off
  assign cs_wake = in_sleep && cmp.main_reg_off && cs_prev && !cs_n;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_prev <= 1'b1;
      irq_status_reg_two <= 1'b0;
    end else begin
      cs_prev <= cs_n;
      irq_status_reg_two <= (irq_two_clr ? 1'b0 : irq_status_reg_two)
                            | cs_wake;
    end
  end

  // ground offset capture at transmit falling edge
  always_comb begin
    canh_low = cmp.canh_below;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_prev <= 1'b1;
      ground_offset_flag <= 1'b0;
    end else begin
      tx_prev <= can_tx;
      ground_offset_flag <= (ground_offset_clr ? 1'b0 : ground_offset_flag)
                            | (tx_prev && !can_tx && canh_low);
    end
  end

  assign forced_wu = fwu_active && period_tick;
  assign host_rst_rel = !rst_in_prev && rst_pin_in && !pulse_busy;
  assign go_reset = ((mode == WMS_NORMAL || mode == WMS_STANDBY) &&
                     wd_fail) ||
                    (mode != WMS_SLEEP && mode != WMS_EMERG &&
                     cmp.main_reg_uv);

  // mode machine
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= WMS_RESET;
      from_forced <= 1'b0;
    end else if (go_reset) begin
      mode <= WMS_RESET;
    end else begin
      unique case (mode)
        WMS_RESET: begin
          if (!pulse_busy) begin
            mode <= WMS_NREQ;
          end
        end
        WMS_NREQ: begin
          if (cmd.configured) begin
            mode <= WMS_NORMAL;
            from_forced <= 1'b0;
          end else if (from_forced && tmo_cnt >= CNT_W'(CFG_TMO)) begin
            mode <= WMS_SLEEP;
            from_forced <= 1'b0;
          end
        end
        WMS_NORMAL, WMS_STANDBY: begin
          if (host_rst_rel) begin
            mode <= WMS_NREQ;
          end else if (cmd.req_sleep) begin
            mode <= WMS_SLEEP;
          end else if (cmd.req_standby) begin
            mode <= WMS_STANDBY;
          end else if (cmd.req_normal) begin
            mode <= WMS_NORMAL;
          end
        end
        WMS_SLEEP: begin
          if (|hit || cs_wake || can_wake || forced_wu) begin
            mode <= WMS_RESET;
            from_forced <= forced_wu;
          end
        end
        WMS_EMERG: begin
          if (host_rst_rel) begin
            mode <= WMS_NREQ;
          end
        end
      endcase
    end
  end

  // configuration timeout counter in normal request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tmo_cnt <= '0;
    end else if (mode == WMS_NREQ) begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end else begin
      tmo_cnt <= '0;
    end
  end

  // reset pulse width counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rst_cnt <= '0;
    end else if (mode == WMS_RESET && rst_cnt < CNT_W'(RST_PULSE)) begin
      rst_cnt <= rst_cnt + 1'b1;
    end else if (mode != WMS_RESET) begin
      rst_cnt <= '0;
    end
  end

  assign pulse_busy = (mode == WMS_RESET) &&
                      (rst_cnt < CNT_W'(RST_PULSE) - 1'b1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rst_in_prev <= 1'b1;
    end else begin
      rst_in_prev <= rst_pin_in;
    end
  end

  // reset pin driven low in reset, sleep and emergency; oe low = drive
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = !(mode == WMS_RESET || mode == WMS_SLEEP ||
                        mode == WMS_EMERG);

  assign main_regulator = !(mode == WMS_SLEEP || mode == WMS_EMERG);
  assign can_regulator = (mode == WMS_NORMAL);
  assign watchdog_run = (mode == WMS_NORMAL || mode == WMS_STANDBY);

  // interrupt: any unmasked source, only in normal and standby
  // local source follows the sticky status so the pin stands until clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(watchdog_run &&
                 |((irq_src |
                    ((|wake_input_status_reg) ? N_IRQ'(1) << IRQ_LOCAL : '0))
                   & ~irq_mask));
    end
  end

endmodule : wms_sequencer

// ===== wms_pkg.sv
// Purpose: constants and types for the wake-up and mode sequencer
// Assumes: one free-running low-frequency clock at 125 MHz nominal
// Notes:   timings derived from named times by expressions
package wms_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  // switched output on-time and sampling instant, in microseconds
  localparam int unsigned SW_ON_US = 400;
  localparam int unsigned SAMPLE_US = 300;
  localparam int unsigned SW_ON_CYC = SW_ON_US * (CLK_HZ / US_PER_S);
  localparam int unsigned SAMPLE_CYC = SAMPLE_US * (CLK_HZ / US_PER_S);
  // reset pulse and configuration timeout, in milliseconds
  localparam int unsigned RST_PULSE_MS = 1;
  localparam int unsigned CFG_TMO_MS = 75;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * CYC_PER_MS;
  localparam int unsigned CFG_TMO_CYC = CFG_TMO_MS * CYC_PER_MS;
  // cyclic periods in ms, index 0..7
  localparam int unsigned PER_MS_0 = 32;
  localparam int unsigned PER_MS_7 = 8192;
  localparam int unsigned CNT_W = 32;

  localparam int unsigned N_WAKE = 3;
  localparam int unsigned N_IRQ = 8;

  // irq source bit positions
  localparam int unsigned IRQ_BAT_OVER = 0;
  localparam int unsigned IRQ_BAT_UNDER = 1;
  localparam int unsigned IRQ_HOT = 2;
  localparam int unsigned IRQ_PREWARN = 3;
  localparam int unsigned IRQ_CAN_FAIL = 4;
  localparam int unsigned IRQ_SPI_ERR = 5;
  localparam int unsigned IRQ_LOCAL = 6;
  localparam int unsigned IRQ_BUS_WAKE = 7;

  typedef enum logic [2:0] {
    WMS_RESET   = 3'b000,
    WMS_NREQ    = 3'b001,
    WMS_NORMAL  = 3'b011,
    WMS_STANDBY = 3'b010,
    WMS_SLEEP   = 3'b110,
    WMS_EMERG   = 3'b111
  } wms_mode_e;

  typedef enum logic [1:0] {
    WMS_OPT_NONE = 2'h0,
    WMS_OPT_RISE = 2'h1,
    WMS_OPT_FALL = 2'h2,
    WMS_OPT_BOTH = 2'h3
  } wms_opt_e;

  // mode requests from the host register side
  typedef struct packed {
    logic req_normal;
    logic req_standby;
    logic req_sleep;
    logic configured;
  } wms_cmd_s;

  // synchronised analog comparator results
  typedef struct packed {
    logic main_reg_off;
    logic main_reg_uv;
    logic canh_below;
  } wms_cmp_s;

endpackage : wms_pkg

// ===== wms_chk.sv
// Purpose: port checker for the wake-up and mode sequencer
// Assumes: one clock mclk, asynchronous active-high rst
// Notes:   bound to the design from the testbench top
`timescale 1ns/1ps
module wms_chk
  import wms_pkg::*;
(
  // clock and reset
  input wire logic                      mclk,
  input wire logic                      rst,
  // watched inputs
  input wire logic [wms_pkg::N_IRQ-1:0] irq_mask,
  input wire logic [wms_pkg::N_IRQ-1:0] irq_src,
  input wire logic                      cs_n,
  input wire logic                      can_tx,
  input wire logic                      wake_status_clr,
  input wire wms_pkg::wms_cmp_s         cmp,
  // watched outputs
  input wire wms_pkg::wms_mode_e        mode,
  input wire logic                      main_regulator,
  input wire logic                      can_regulator,
  input wire logic                      watchdog_run,
  input wire logic                      rst_pin_oe,
  input wire logic                      irq_n,
  input wire logic [wms_pkg::N_WAKE-1:0] wake_input_status_reg,
  input wire logic                      irq_status_reg_two,
  input wire logic                      ground_offset_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  AST_SLEEP_REG: assert property (mode == WMS_SLEEP |->
    !main_regulator && !can_regulator && !rst_pin_oe)
    else $error("regulators or reset pin wrong in sleep");
  AST_SLEEP_IRQ: assert property (
    mode == WMS_SLEEP ##1 mode == WMS_SLEEP |-> irq_n)
    else $error("interrupt active in sleep");
  AST_WD_RUN: assert property (watchdog_run ==
    (mode == WMS_NORMAL || mode == WMS_STANDBY))
    else $error("watchdog run state wrong for mode");
  AST_RST_LOW: assert property (mode == WMS_RESET |-> !rst_pin_oe)
    else $error("reset pin not driven low in reset state");
  AST_PULSE: assert property ($rose(mode == WMS_RESET) |->
    (mode == WMS_RESET) [*7] ##[1:3] mode == WMS_NREQ)
    else $error("reset pulse length wrong");
  AST_CS_WAKE: assert property (
    mode == WMS_SLEEP && cmp.main_reg_off && $fell(cs_n)
    |=> irq_status_reg_two ##[0:2] mode != WMS_SLEEP)
    else $error("chip select wake missed");
  AST_GND: assert property ($fell(can_tx) && cmp.canh_below
    |=> ground_offset_flag)
    else $error("ground offset flag not set");
  AST_IRQ: assert property (mode == WMS_NORMAL &&
    |(irq_src & ~irq_mask) |-> ##[1:2] !irq_n)
    else $error("unmasked interrupt not raised");
  AST_NREQ_NODET: assert property (
    mode == WMS_NREQ && !wake_status_clr |=> $stable(wake_input_status_reg))
    else $error("local wake detected in normal request");
endmodule : wms_chk

// ===== wms_host.sv
// Purpose: host side of the shared reset pin
// Assumes: pin has a pull-up; host only ever pulls low
// Notes:   pin level resolved from both parties
`timescale 1ns/1ps
module wms_host (
  // device side
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe,
  // host side
  input  wire logic host_pull,
  output logic      rst_pin_in
);
  // pull-up wins when nobody drives
  assign rst_pin_in = (rst_pin_oe ? 1'b1 : rst_pin_out) & ~host_pull;
endmodule : wms_host

// ===== wakeup_mode_sequencer_test.sv
// Purpose: self-checking bench for the wake-up and mode sequencer
// Assumes: shortened counts MS_CYC 10, RST_PULSE 8, CFG_TMO 50
// Notes:   host reset pin modelled in wms_host
`timescale 1ns/1ps
module wakeup_mode_sequencer_test;
  import wms_pkg::*;
  localparam wms_cmd_s C_NORM = 4'b1001;
  localparam wms_cmd_s C_SLP  = 4'b0011;
  localparam wms_cmd_s C_IDLE = 4'b0001;
  logic mclk, rst, cyc_en, fwu_en, from_sw, sw_req, host_pull;
  logic ws_clr, i2_clr, go_clr, cs_n, can_tx, can_wake, wd_fail;
  logic rst_in, rst_out, rst_oe, irq_n, m_reg, c_reg, sw_out, wd_run;
  logic i2_flag, go_flag;
  logic [2:0] ctr, lwi, live, wstat;
  logic [1:0] gol;
  logic [7:0] mask, src;
  wms_opt_e opt;
  wms_cmd_s cmd;
  wms_cmp_s cmp;
  wms_mode_e mode;
  int error_cnt, samples_checked, cycles;

  wms_sequencer #(.CFG_TMO(50), .RST_PULSE(8), .MS_CYC(10)) u_dut (
    .mclk(mclk), .rst(rst), .cyclic_timing_reg(ctr), .cyclic_en(cyc_en),
    .forced_wake_en(fwu_en), .wake_from_switched(from_sw),
    .wake_opt(opt), .ground_offset_level(gol), .irq_mask(mask),
    .switched_on_req(sw_req), .cmd(cmd), .wake_status_clr(ws_clr),
    .irq_two_clr(i2_clr), .ground_offset_clr(go_clr),
    .local_wake_inputs(lwi), .irq_src(src), .cs_n(cs_n),
    .can_tx(can_tx), .can_wake(can_wake), .wd_fail(wd_fail), .cmp(cmp),
    .rst_pin_in(rst_in), .mode(mode), .main_regulator(m_reg),
    .can_regulator(c_reg), .switched_battery_out(sw_out),
    .watchdog_run(wd_run), .rst_pin_out(rst_out), .rst_pin_oe(rst_oe),
    .irq_n(irq_n), .wake_input_live_reg(live),
    .wake_input_status_reg(wstat), .irq_status_reg_two(i2_flag),
    .ground_offset_flag(go_flag));

  wms_host u_host (.rst_pin_out(rst_out), .rst_pin_oe(rst_oe),
    .host_pull(host_pull), .rst_pin_in(rst_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h",
               $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wait_mode(input wms_mode_e m);
    int k;
    k = 0;
    while (mode !== m && k < 500) begin
      tick(1);
      k++;
    end
    chk(mode, m);
  endtask : wait_mode

  task automatic go(input wms_cmd_s c, input wms_mode_e m);
    @(posedge mclk);
    cmd <= c;
    wait_mode(m);
    @(posedge mclk);
    cmd <= C_IDLE;
  endtask : go

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    rst <= 1'b1; ctr <= 3'h0; cyc_en <= 1'b0; fwu_en <= 1'b0;
    from_sw <= 1'b0; opt <= WMS_OPT_RISE; gol <= 2'h0; mask <= 8'hff;
    sw_req <= 1'b0; cmd <= C_IDLE; ws_clr <= 1'b0; i2_clr <= 1'b0;
    go_clr <= 1'b0; lwi <= 3'h0; src <= 8'h00; cs_n <= 1'b1;
    can_tx <= 1'b1; can_wake <= 1'b0; wd_fail <= 1'b0;
    cmp <= 3'h0; host_pull <= 1'b0;
    tick(20);
    chk(rst_oe, 1'b0);
    rst <= 1'b0;
    tick(2);
    chk(mode, WMS_RESET);
    wait_mode(WMS_NREQ);
    go(C_NORM, WMS_NORMAL);
    chk({m_reg, c_reg, wd_run}, 3'h7);
    $display("test reset and normal done");
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      src <= 8'h01 << i;
      mask <= 8'h00;
      tick(3);
      chk(irq_n, 1'b0);
      mask <= 8'h01 << i;
      tick(3);
      chk(irq_n, 1'b1);
      src <= 8'h00;
    end
    mask <= 8'hbf;
    lwi <= 3'h2;
    tick(3);
    chk(live, 3'h2);
    chk(wstat, 3'h2);
    chk(irq_n, 1'b0);
    ws_clr <= 1'b1;
    tick(1);
    ws_clr <= 1'b0;
    lwi <= 3'h0;
    mask <= 8'hff;
    tick(3);
    chk(wstat, 3'h0);
    $display("test interrupts and local wake done");
    for (int lv = 0; lv < 4; lv++) begin
      @(posedge mclk);
      gol <= lv[1:0];
      cmp.canh_below <= lv[0];
      can_tx <= 1'b0;
      tick(2);
      chk(go_flag, lv[0]);
      can_tx <= 1'b1;
      go_clr <= 1'b1;
      tick(1);
      go_clr <= 1'b0;
    end
    $display("test ground offset done");
    wd_fail <= 1'b1;
    tick(1);
    wd_fail <= 1'b0;
    wait_mode(WMS_RESET);
    wait_mode(WMS_NREQ);
    go(C_NORM, WMS_NORMAL);
    host_pull <= 1'b1;
    tick(5);
    host_pull <= 1'b0;
    wait_mode(WMS_NREQ);
    $display("test watchdog and host reset done");
    go(C_NORM, WMS_NORMAL);
    go(C_SLP, WMS_SLEEP);
    tick(2);
    chk({m_reg, c_reg, irq_n, rst_oe}, 4'h2);
    cmp.main_reg_off <= 1'b1;
    cs_n <= 1'b0;
    tick(2);
    chk(i2_flag, 1'b1);
    wait_mode(WMS_NREQ);
    cs_n <= 1'b1;
    cmp.main_reg_off <= 1'b0;
    i2_clr <= 1'b1;
    tick(1);
    i2_clr <= 1'b0;
    go(C_NORM, WMS_NORMAL);
    go(C_SLP, WMS_SLEEP);
    lwi <= 3'h1;
    tick(2);
    chk(wstat, 3'h1);
    wait_mode(WMS_NREQ);
    ws_clr <= 1'b1;
    tick(1);
    ws_clr <= 1'b0;
    $display("test sleep wakes done");
    go(C_NORM, WMS_NORMAL);
    fwu_en <= 1'b1;
    go(C_SLP, WMS_SLEEP);
    @(posedge mclk);
    cmd <= 4'h0;
    wait_mode(WMS_NREQ);
    wait_mode(WMS_SLEEP);
    $display("test forced wake timeout done");
    end_sim();
  end
endmodule : wakeup_mode_sequencer_test

bind wms_sequencer wms_chk u_chk (.mclk(mclk), .rst(rst),
  .irq_mask(irq_mask), .irq_src(irq_src), .cs_n(cs_n), .can_tx(can_tx),
  .wake_status_clr(wake_status_clr), .cmp(cmp), .mode(mode),
  .main_regulator(main_regulator), .can_regulator(can_regulator),
  .watchdog_run(watchdog_run), .rst_pin_oe(rst_pin_oe), .irq_n(irq_n),
  .wake_input_status_reg(wake_input_status_reg),
  .irq_status_reg_two(irq_status_reg_two),
  .ground_offset_flag(ground_offset_flag));
